// [aux_update_unit.sv]
// shared constants for the store-aux-register decoder and the pointer update unit

// ----------------------------------------------------------------
// constants
// ----------------------------------------------------------------
package store_aux_pkg;
	localparam int          WORD_W        = 16;
	localparam int          SEL_W         = 3;
	localparam int          AUX_COUNT     = 8;
	localparam int          PAGE_W        = 9;
	localparam int          OFFSET_W      = 7;
	localparam int          WAIT_W        = 4;
	localparam int          REP_W         = 8;
	localparam int          CNT_W         = 5;
	// opcode layout
	localparam int          OPC_HI        = 15;
	localparam int          OPC_LO        = 11;
	localparam logic [4:0]  OPC_VALUE     = 5'h10;
	localparam int          SEL_HI        = 10;
	localparam int          SEL_LO        = 8;
	localparam int          MODE_BIT      = 7;
	localparam int          OFF_HI        = 6;
	localparam int          OFF_LO        = 0;
	localparam int          UPD_HI        = 6;
	localparam int          UPD_LO        = 4;
	localparam int          NFLAG_BIT     = 3;
	localparam int          NPTR_HI       = 2;
	localparam int          NPTR_LO       = 0;
	// update codes
	localparam logic [2:0]  UPD_NONE      = 3'h0;
	localparam logic [2:0]  UPD_DEC       = 3'h1;
	localparam logic [2:0]  UPD_INC       = 3'h2;
	localparam logic [2:0]  UPD_SPARE     = 3'h3;
	localparam logic [2:0]  UPD_BR_SUB    = 3'h4;
	localparam logic [2:0]  UPD_IDX_SUB   = 3'h5;
	localparam logic [2:0]  UPD_IDX_ADD   = 3'h6;
	localparam logic [2:0]  UPD_BR_ADD    = 3'h7;
	// cycle figures
	localparam logic [CNT_W-1:0] BASE_CYCLES     = 5'h01;
	localparam logic [CNT_W-1:0] EXT_OP_CYCLES   = 5'h02;
	localparam logic [CNT_W-1:0] BOTH_EXT_EXTRA  = 5'h02;
	localparam logic [CNT_W-1:0] SHARED_ONE_EX   = 5'h01;
	localparam logic [CNT_W-1:0] SHARED_REP_EX   = 5'h02;
	// reset values and state encodings
	localparam logic [WORD_W-1:0] AUX_RESET   = 16'h0000;
	localparam logic [SEL_W-1:0]  PTR_RESET   = 3'h0;
	localparam logic [2:0]  ST_IDLE       = 3'b001;
	localparam logic [2:0]  ST_OVERHEAD   = 3'b010;
	localparam logic [2:0]  ST_EXEC       = 3'b100;

	typedef enum logic [2:0] {
		IDLE     = 3'b001,
		OVERHEAD = 3'b010,
		EXEC     = 3'b100
	} exec_state_e;
endpackage

// ----------------------------------------------------------------
// indirect pointer update
// ----------------------------------------------------------------
module aux_update_unit
	import store_aux_pkg::*;
(
	input  wire logic [2:0]        updateCode,
	input  wire logic [WORD_W-1:0] current,
	input  wire logic [WORD_W-1:0] indexValue,
	output logic      [WORD_W-1:0] updated
);

	// mirror a word end for end
	function automatic logic [WORD_W-1:0] reverseBits(input logic [WORD_W-1:0] v);
		logic [WORD_W-1:0] r;
		r = '0;
		for (int i = 0; i < WORD_W; i++) begin
			r[i] = v[WORD_W-1-i];
		end
		return r;
	endfunction

	// carry runs downward for bit-reversed steps, used by fft-style buffers
	always_comb begin
		case (updateCode)
			UPD_NONE:    updated = current;
			UPD_DEC:     updated = current - 16'h0001;
			UPD_INC:     updated = current + 16'h0001;
			UPD_IDX_SUB: updated = current - indexValue;
			UPD_IDX_ADD: updated = current + indexValue;
			UPD_BR_ADD:  updated = reverseBits(reverseBits(current) + reverseBits(indexValue));
			UPD_BR_SUB:  updated = reverseBits(reverseBits(current) - reverseBits(indexValue));
			default:     updated = current; // spare code leaves the pointer alone
		endcase
	end

endmodule

// [store_aux_register_instr.sv]
// decode and execution timing of the store-auxiliary-register instruction

// ----------------------------------------------------------------
// module
// ----------------------------------------------------------------
// What this block does
// - direct form: bits 15..11 = 10000, 10..8 source, bit7 zero, 6..0 offset
// - indirect low field splits into update code, next-pointer flag, pointer value
// - source select 0..7 picks which auxiliary register is stored
// - indirect form with flag set loads next pointer value into the pointer
// - indirect supports none, inc, dec, index add/sub, bit-reversed add/sub
// - direct address is data page on top of seven instruction bits
// - execution bumps program counter and stores full selected register
// - stored value is the one before the pointer update is applied
// - single run: 1, 1+p, 2+d or 4+d+p cycles by memory placement
// - same single-access block: 2 cycles single, n+2 repeated
// - repeated n: n, n+p, 2n+nd or 2n+2+nd+p cycles
module store_aux_register_instr
	import store_aux_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              reset,
	input  wire logic              instrValid,
	input  wire logic [WORD_W-1:0] instrWord,
	input  wire logic [PAGE_W-1:0] dataPage,
	input  wire logic [REP_W-1:0]  repeatCount,
	input  wire logic              progExternal,
	input  wire logic              operandExternal,
	input  wire logic              sameSingleAccessRam,
	input  wire logic [WAIT_W-1:0] progWait,
	input  wire logic [WAIT_W-1:0] dataWait,
	input  wire logic              auxLoad,
	input  wire logic [SEL_W-1:0]  auxLoadSel,
	input  wire logic [WORD_W-1:0] auxLoadData,
	input  wire logic [SEL_W-1:0]  auxReadSel,
	output logic                   instrAccept,
	output logic                   pcIncrement,
	output logic                   busy,
	output logic                   done,
	output logic                   memWrite,
	output logic      [WORD_W-1:0] memAddr,
	output logic      [WORD_W-1:0] memData,
	output logic      [SEL_W-1:0]  auxPointer,
	output logic      [WORD_W-1:0] auxReadData
);

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	logic                   opcodeMatch;
	logic                   indirectForm;
	logic [CNT_W-1:0]       perIter;
	logic [CNT_W-1:0]       overheadCycles;
	logic [REP_W-1:0]       iterTotal;

	// decode and cycle cost are computed from the live word at acceptance
	always_comb begin
		opcodeMatch  = (instrWord[OPC_HI:OPC_LO] == OPC_VALUE);
		indirectForm = instrWord[MODE_BIT];
		iterTotal    = (repeatCount == 8'h00) ? 8'h01 : repeatCount;
		// per-execution cost: operand off chip costs 2+d each time
		perIter = operandExternal ? (EXT_OP_CYCLES + CNT_W'(dataWait)) : BASE_CYCLES;
		// one-off cost paid once per instruction, repeated or not
		if (progExternal && operandExternal) begin
			overheadCycles = BOTH_EXT_EXTRA + CNT_W'(progWait);
		end else if (progExternal) begin
			overheadCycles = CNT_W'(progWait);
		end else if (!operandExternal && sameSingleAccessRam) begin
			overheadCycles = (iterTotal == 8'h01) ? SHARED_ONE_EX : SHARED_REP_EX;
		end else begin
			overheadCycles = '0;
		end
	end

	// ------------------------------------------------------------
	// latched instruction fields
	// ------------------------------------------------------------
	logic                   isIndirect,    next_isIndirect;
	logic [SEL_W-1:0]       sourceSel,     next_sourceSel;
	logic [OFFSET_W-1:0]    directOffset,  next_directOffset;
	logic [PAGE_W-1:0]      pageLatch,     next_pageLatch;
	logic [2:0]             auxUpdateCode, next_auxUpdateCode;
	logic                   nextPtrFlag,   next_nextPtrFlag;
	logic [SEL_W-1:0]       nextPtrValue,  next_nextPtrValue;
	logic [CNT_W-1:0]       iterCycles,    next_iterCycles;

	// fields are held for the whole run so a repeat reuses them unchanged
	always_comb begin
		next_isIndirect    = isIndirect;
		next_sourceSel     = sourceSel;
		next_directOffset  = directOffset;
		next_pageLatch     = pageLatch;
		next_auxUpdateCode = auxUpdateCode;
		next_nextPtrFlag   = nextPtrFlag;
		next_nextPtrValue  = nextPtrValue;
		next_iterCycles    = iterCycles;
		if (instrAccept) begin
			next_isIndirect    = indirectForm;
			next_sourceSel     = instrWord[SEL_HI:SEL_LO];
			next_directOffset  = instrWord[OFF_HI:OFF_LO];
			next_pageLatch     = dataPage;
			next_auxUpdateCode = instrWord[UPD_HI:UPD_LO];
			next_nextPtrFlag   = instrWord[NFLAG_BIT];
			next_nextPtrValue  = instrWord[NPTR_HI:NPTR_LO];
			next_iterCycles    = perIter;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			isIndirect    <= 1'b0;
			sourceSel     <= '0;
			directOffset  <= '0;
			pageLatch     <= '0;
			auxUpdateCode <= UPD_NONE;
			nextPtrFlag   <= 1'b0;
			nextPtrValue  <= '0;
			iterCycles    <= BASE_CYCLES;
		end else begin
			isIndirect    <= next_isIndirect;
			sourceSel     <= next_sourceSel;
			directOffset  <= next_directOffset;
			pageLatch     <= next_pageLatch;
			auxUpdateCode <= next_auxUpdateCode;
			nextPtrFlag   <= next_nextPtrFlag;
			nextPtrValue  <= next_nextPtrValue;
			iterCycles    <= next_iterCycles;
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	exec_state_e            state,    next_state;
	logic [CNT_W-1:0]       cycleCnt, next_cycleCnt;
	logic [REP_W-1:0]       iterLeft, next_iterLeft;
	logic                   storeNow;

	// a word is only taken when idle; others on the bus are not ours
	assign instrAccept = instrValid && opcodeMatch && (state == IDLE);
	assign busy        = (state != IDLE);

	always_comb begin
		next_state    = state;
		next_cycleCnt = cycleCnt;
		next_iterLeft = iterLeft;
		storeNow      = 1'b0;
		case (state)
			IDLE: begin
				if (instrAccept) begin
					next_iterLeft = iterTotal;
					if (overheadCycles != '0) begin
						next_state    = OVERHEAD;
						next_cycleCnt = overheadCycles - 5'h01;
					end else begin
						next_state    = EXEC;
						next_cycleCnt = perIter - 5'h01;
					end
				end
			end
			OVERHEAD: begin
				if (cycleCnt == '0) begin
					next_state    = EXEC;
					next_cycleCnt = iterCycles - 5'h01;
				end else begin
					next_cycleCnt = cycleCnt - 5'h01;
				end
			end
			EXEC: begin
				if (cycleCnt == '0) begin
					storeNow = 1'b1; // store lands at the end of each execution
					if (iterLeft == 8'h01) begin
						next_state = IDLE;
					end else begin
						next_iterLeft = iterLeft - 8'h01;
						next_cycleCnt = iterCycles - 5'h01;
					end
				end else begin
					next_cycleCnt = cycleCnt - 5'h01;
				end
			end
			default: begin
				next_state = IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state    <= IDLE;
			cycleCnt <= '0;
			iterLeft <= '0;
		end else begin
			state    <= next_state;
			cycleCnt <= next_cycleCnt;
			iterLeft <= next_iterLeft;
		end
	end

	// ------------------------------------------------------------
	// auxiliary registers and pointer
	// ------------------------------------------------------------
	logic [WORD_W-1:0]      auxReg [AUX_COUNT];
	logic [WORD_W-1:0]      next_auxReg [AUX_COUNT];
	logic [SEL_W-1:0]       arPtr, next_arPtr;
	logic [WORD_W-1:0]      pointedValue;
	logic [WORD_W-1:0]      updatedValue;

	assign pointedValue = auxReg[arPtr];
	assign auxReadData  = auxReg[auxReadSel];
	assign auxPointer   = arPtr;

	aux_update_unit aux_update_unit_i (
		.updateCode (auxUpdateCode),
		.current    (pointedValue),
		.indexValue (auxReg[0]),
		.updated    (updatedValue)
	);

	// outside loads are refused mid-run so the pointer walk stays coherent
	always_comb begin
		for (int i = 0; i < AUX_COUNT; i++) begin
			next_auxReg[i] = auxReg[i];
		end
		next_arPtr = arPtr;
		if (!busy && auxLoad) begin
			next_auxReg[auxLoadSel] = auxLoadData;
		end
		if (storeNow && isIndirect) begin
			// update registers at the same edge the old value is captured
			next_auxReg[arPtr] = updatedValue;
			if (nextPtrFlag) begin
				next_arPtr = nextPtrValue;
			end
		end
	end

	generate
		for (genvar g = 0; g < AUX_COUNT; g++) begin : g_aux
			always_ff @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					auxReg[g] <= AUX_RESET;
				end else begin
					auxReg[g] <= next_auxReg[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			arPtr <= PTR_RESET;
		end else begin
			arPtr <= next_arPtr;
		end
	end

	// ------------------------------------------------------------
	// memory write port and completion
	// ------------------------------------------------------------
	logic                   next_memWrite;
	logic [WORD_W-1:0]      next_memAddr;
	logic [WORD_W-1:0]      next_memData;
	logic                   next_done;
	logic                   next_pcIncrement;

	// no status flag is produced here at all, and the pc moves by one word
	always_comb begin
		next_memWrite    = storeNow;
		next_memAddr     = memAddr;
		next_memData     = memData;
		next_done        = storeNow && (iterLeft == 8'h01);
		next_pcIncrement = instrAccept;
		if (storeNow) begin
			next_memData = auxReg[sourceSel];
			if (isIndirect) begin
				next_memAddr = pointedValue;
			end else begin
				next_memAddr = {pageLatch, directOffset};
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			memWrite    <= 1'b0;
			memAddr     <= '0;
			memData     <= '0;
			done        <= 1'b0;
			pcIncrement <= 1'b0;
		end else begin
			memWrite    <= next_memWrite;
			memAddr     <= next_memAddr;
			memData     <= next_memData;
			done        <= next_done;
			pcIncrement <= next_pcIncrement;
		end
	end

endmodule

// [store_aux_register_instr_asserts.sv]
// concurrent checks on the ports of the store-aux-register decoder
module store_aux_register_instr_asserts
	import store_aux_pkg::*;
(
	input wire logic              clk_sys,
	input wire logic              reset,
	input wire logic [WORD_W-1:0] instrWord,
	input wire logic [PAGE_W-1:0] dataPage,
	input wire logic [REP_W-1:0]  repeatCount,
	input wire logic              progExternal,
	input wire logic              operandExternal,
	input wire logic              sameSingleAccessRam,
	input wire logic              instrAccept,
	input wire logic              pcIncrement,
	input wire logic              busy,
	input wire logic              done,
	input wire logic              memWrite,
	input wire logic [WORD_W-1:0] memAddr,
	input wire logic [SEL_W-1:0]  auxPointer
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	// accepted single run with program and operand both on chip
	sequence s_int_single;
		instrAccept && !progExternal && !operandExternal && repeatCount <= 8'h01;
	endsequence
	// one busy cycle then the closing write
	sequence s_one_exec;
		busy ##1 (memWrite && done && !busy);
	endsequence

	a_accept_only_idle: assert property (instrAccept |-> !busy && instrWord[OPC_HI:OPC_LO] == OPC_VALUE)
		else $error("accept while busy or on a foreign opcode");
	a_pc_then_busy: assert property (instrAccept |=> pcIncrement && busy)
		else $error("no pc step after accept");
	a_single_on_chip: assert property (s_int_single and !sameSingleAccessRam |=> s_one_exec)
		else $error("on-chip single run not one cycle");
	a_shared_block_time: assert property (s_int_single and sameSingleAccessRam |=> busy[*2] ##1 done)
		else $error("shared single-access run not two cycles");
	a_direct_address: assert property (s_int_single and !sameSingleAccessRam && !instrWord[MODE_BIT]
		|=> ##1 memAddr == {$past(dataPage, 2), $past(instrWord[OFF_HI:OFF_LO], 2)})
		else $error("direct address not page plus offset");
	a_direct_keeps_ptr: assert property (instrAccept && !instrWord[MODE_BIT] |=> $stable(auxPointer)[*2])
		else $error("direct form moved the pointer");
	a_done_with_write: assert property (done |-> memWrite && !busy)
		else $error("done without final write");
	a_pc_single_pulse: assert property (pcIncrement |=> !pcIncrement)
		else $error("pc stepped twice");
endmodule

// [test_store_aux_register_instr.sv]
// self-checking bench for the store-aux-register decoder
module test_store_aux_register_instr import store_aux_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic              clk_sys, reset, instrValid, auxLoad, instrAccept, pcIncrement, busy, done;
	logic              progExternal, operandExternal, sameSingleAccessRam, memWrite;
	logic [WORD_W-1:0] instrWord, auxLoadData, memAddr, memData, auxReadData;
	logic [PAGE_W-1:0] dataPage;
	logic [REP_W-1:0]  repeatCount;
	logic [WAIT_W-1:0] progWait, dataWait;
	logic [SEL_W-1:0]  auxLoadSel, auxReadSel, auxPointer;
	logic [WORD_W-1:0] wrAddr[$], wrData[$];
	int                n_mismatch, n_checks, busyCnt, pcCnt;

	store_aux_register_instr store_aux_register_instr_i (.clk_sys, .reset, .instrValid, .instrWord,
		.dataPage, .repeatCount, .progExternal, .operandExternal, .sameSingleAccessRam, .progWait,
		.dataWait, .auxLoad, .auxLoadSel, .auxLoadData, .auxReadSel, .instrAccept, .pcIncrement,
		.busy, .done, .memWrite, .memAddr, .memData, .auxPointer, .auxReadData);

	// 250 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [WORD_W-1:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	function automatic logic [15:0] rev(logic [15:0] v);
		return {<<{v}};
	endfunction

	// post-store value of the pointed register for each update code
	function automatic logic [15:0] expUpd(logic [2:0] c, logic [15:0] v, i);
		case (c)
			UPD_DEC: return v - 16'h0001;
			UPD_INC: return v + 16'h0001;
			UPD_IDX_SUB: return v - i;
			UPD_IDX_ADD: return v + i;
			UPD_BR_SUB: return rev(rev(v) - rev(i));
			UPD_BR_ADD: return rev(rev(v) + rev(i));
			default: return v;
		endcase
	endfunction

	// busy length by memory placement, worked from the cycle tables
	function automatic int expT(int n, bit pe, oe, sr, int p, d);
		if (pe && oe) return 2 * n + 2 + n * d + p;
		if (oe) return 2 * n + n * d;
		if (pe) return n + p;
		if (sr) return (n == 1) ? 2 : n + 2;
		return n;
	endfunction

	task automatic load(input logic [2:0] sel, input logic [15:0] val);
		@(posedge clk_sys);
		auxLoad <= 1'b1;
		auxLoadSel <= sel;
		auxLoadData <= val;
		@(posedge clk_sys);
		auxLoad <= 1'b0;
	endtask

	// offer one word, then log busy cycles, pc steps and writes until done
	task automatic issue(input logic [15:0] w, input logic [7:0] n, input logic pe, oe, sr,
		input logic [3:0] p, d);
		int k;
		@(posedge clk_sys);
		instrValid <= 1'b1;
		instrWord <= w;
		repeatCount <= n;
		progExternal <= pe;
		operandExternal <= oe;
		sameSingleAccessRam <= sr;
		progWait <= p;
		dataWait <= d;
		#1 check("accept", 16'(instrAccept), 16'h0001);
		@(posedge clk_sys);
		instrValid <= 1'b0;
		wrAddr.delete();
		wrData.delete();
		busyCnt = 0;
		pcCnt = 0;
		// first look lands in the cycle right after the accepting edge
		for (k = 0; k < 300; k++) begin
			#1;
			if (busy === 1'b1) busyCnt++;
			if (pcIncrement === 1'b1) pcCnt++;
			if (memWrite === 1'b1) begin
				wrAddr.push_back(memAddr);
				wrData.push_back(memData);
			end
			if (done === 1'b1) break;
			@(posedge clk_sys);
		end
		check("finished", 16'(k < 300), 16'h0001);
		check("pc steps", 16'(pcCnt), 16'h0001);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_refuse();
		@(posedge clk_sys);
		instrValid <= 1'b1;
		instrWord <= 16'h9000;
		#1 check("foreign accept", 16'(instrAccept), 16'h0000);
		@(posedge clk_sys);
		instrValid <= 1'b0;
	endtask

	task automatic t_sources();
		for (int x = 0; x < 8; x++) load(3'(x), 16'hA050 + 16'(x) * 16'h0111);
		for (int x = 0; x < 8; x++) begin
			issue({5'h10, 3'(x), 1'b0, 7'h5A}, 8'h01, 1'b0, 1'b0, 1'b0, 4'h0, 4'h0);
			check("direct addr", wrAddr[0], {dataPage, 7'h5A});
			check("direct data", wrData[0], 16'hA050 + 16'(x) * 16'h0111);
		end
	endtask

	task automatic t_indirect();
		auxReadSel <= 3'h2;
		issue({5'h10, 3'h0, 1'b1, UPD_NONE, 1'b1, 3'h2}, 8'h01, 1'b0, 1'b0, 1'b0, 4'h0, 4'h0);
		check("next pointer", 16'(auxPointer), 16'h0002);
		load(3'h0, 16'h0013);
		for (int c = 0; c < 8; c++) begin
			load(3'h2, 16'h0A28);
			issue({5'h10, 3'h2, 1'b1, 3'(c), 1'b0, 3'h5}, 8'h01, 1'b0, 1'b0, 1'b0, 4'h0, 4'h0);
			check("indirect addr", wrAddr[0], 16'h0A28);
			check("old value", wrData[0], 16'h0A28);
			check("updated", auxReadData, expUpd(3'(c), 16'h0A28, 16'h0013));
		end
		check("pointer kept", 16'(auxPointer), 16'h0002);
		load(3'h2, 16'h0100);
		issue({5'h10, 3'h2, 1'b1, UPD_INC, 1'b0, 3'h0}, 8'h03, 1'b0, 1'b0, 1'b0, 4'h0, 4'h0);
		for (int k = 0; k < 3; k++) begin
			check("repeat addr", wrAddr[k], 16'h0100 + 16'(k));
			check("repeat data", wrData[k], 16'h0100 + 16'(k));
		end
	endtask

	task automatic t_timing();
		bit [2:0] cfg [5] = '{3'b000, 3'b100, 3'b010, 3'b110, 3'b001};
		int n;
		for (int i = 0; i < 5; i++) begin
			for (int j = 0; j < 2; j++) begin
				n = j ? 4 : 1;
				issue({5'h10, 3'h1, 1'b0, 7'h11}, 8'(n), cfg[i][2], cfg[i][1], cfg[i][0], 4'h3, 4'h2);
				check("busy cycles", 16'(busyCnt), 16'(expT(n, cfg[i][2], cfg[i][1], cfg[i][0], 3, 2)));
				check("write count", 16'(wrAddr.size()), 16'(n));
			end
		end
	endtask

	// watchdog: the full run needs a few hundred cycles at most
	initial begin
		#40000;
		n_mismatch++;
		complete_run();
	end

	// reset, then each scenario in turn
	initial begin
		reset = 1'b1;
		{instrValid, auxLoad, progExternal, operandExternal, sameSingleAccessRam} = 5'h00;
		instrWord = 16'h0000;
		auxLoadData = 16'h0000;
		dataPage = 9'h1A5;
		repeatCount = 8'h01;
		{progWait, dataWait} = 8'h00;
		{auxLoadSel, auxReadSel} = 6'h00;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		t_refuse();
		t_sources();
		t_indirect();
		t_timing();
		complete_run();
	end
endmodule

bind store_aux_register_instr store_aux_register_instr_asserts store_aux_register_instr_asserts_i (
	.clk_sys, .reset, .instrWord, .dataPage, .repeatCount, .progExternal, .operandExternal,
	.sameSingleAccessRam, .instrAccept, .pcIncrement, .busy, .done, .memWrite, .memAddr, .auxPointer);
